// ---- dv/host_tuner.sv ----
// Purpose: Host model that writes the threshold offset and filter enable.
// Assumes: Its tasks are called just after a falling clock edge.
// Notes:   Between writes the setting lines carry junk to expose unqualified loads.
`timescale 1ns/1ns
module host_tuner
    import load_meas_pkg::*;
(
    input  wire logic           clock,
    output logic                cfg_write,
    output logic [OFFSET_W-1:0] cfg_offset,
    output logic                cfg_filter_en
);
    int cur_offset;

    // Tuning starts from a zero offset with the filter off.
    initial begin
        cur_offset    = 0;
        cfg_write     = 1'b0;
        cfg_offset    = 7'h00;
        cfg_filter_en = 1'b0;
    end

    // Writes both settings in one pulse, then scrambles the idle lines.
    task automatic write_cfg(input int off, input logic filt);
        cur_offset    = (off < -10) ? -10 : off;
        cfg_offset    = cur_offset[OFFSET_W-1:0];
        cfg_filter_en = filt;
        cfg_write     = 1'b1;
        @(negedge clock);
        cfg_write     = 1'b0;
        cfg_offset    = ~cfg_offset;
        cfg_filter_en = ~cfg_filter_en;
    endtask : write_cfg

    // Lowers the offset when the motor stalled first, raises it otherwise.
    task automatic tune(input logic stalled_first, input logic filt);
        write_cfg(stalled_first ? cur_offset - 1 : cur_offset + 1, filt);
    endtask : tune
endmodule : host_tuner

// ---- dv/tb_motor_load_measurement.sv ----
// Purpose: Self-checking bench for the motor load measurement unit.
// Assumes: Inputs change at the falling edge; outputs are read there.
// Notes:   Expected loads are rebuilt from the offset scaling and saturation.
`timescale 1ns/1ns
module tb_motor_load_measurement
    import load_meas_pkg::*;
();
    logic                clock, nrst, full_step, cfg_write, cfg_filter_en;
    logic                load_filter_enable, stall_flag_out, load_update;
    logic [LOAD_W-1:0]   raw_load, load_measure_value;
    logic [OFFSET_W-1:0] cfg_offset, stall_threshold_offset;
    logic [31:0]         seed;
    int                  fails, compares;

    motor_load_measurement motor_load_measurement_inst (.clock(clock), .nrst(nrst),
        .full_step(full_step), .raw_load(raw_load), .cfg_write(cfg_write),
        .cfg_offset(cfg_offset), .cfg_filter_en(cfg_filter_en),
        .stall_threshold_offset(stall_threshold_offset),
        .load_filter_enable(load_filter_enable), .load_measure_value(load_measure_value),
        .stall_flag_out(stall_flag_out), .load_update(load_update));
    host_tuner host_tuner_inst (.clock(clock), .cfg_write(cfg_write),
        .cfg_offset(cfg_offset), .cfg_filter_en(cfg_filter_en));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    // Shifts the source by the scaled offset and clamps to the value range.
    function automatic logic [LOAD_W-1:0] exp_load(input int src, input int off);
        int v;
        v = src + off * (1 << OFFSET_SHIFT);
        v = (v < 0) ? 0 : v;
        v = (v > int'(LOAD_MAX)) ? int'(LOAD_MAX) : v;
        return v[LOAD_W-1:0];
    endfunction : exp_load

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic drive(input logic s, input logic [LOAD_W-1:0] r);
        full_step = s;
        raw_load  = r;
        @(negedge clock);
    endtask : drive

    // Writes the settings and reads them back one cycle later.
    task automatic set_cfg(input int off, input logic filt);
        host_tuner_inst.write_cfg(off, filt);
        check("offset", 16'(stall_threshold_offset), 16'(off[OFFSET_W-1:0]));
        check("filter", 16'(load_filter_enable), 16'(filt));
    endtask : set_cfg

    // One unfiltered full step with its outcome checked one cycle later.
    task automatic unf_step(input logic [LOAD_W-1:0] r);
        logic [LOAD_W-1:0] e;
        e = exp_load(int'(r), host_tuner_inst.cur_offset);
        drive(1'b1, r);
        check("update", 16'(load_update), 16'h0001);
        check("value", 16'(load_measure_value), 16'(e));
        check("stall", 16'(stall_flag_out), 16'(e == '0));
    endtask : unf_step

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        repeat (3000) @(posedge clock);
        fails++;
        finish_test();
    end

    initial begin
        int          offs [5];
        int          raws [5];
        int          sum;
        logic [31:0] r;
        logic [LOAD_W-1:0] e;
        offs = '{0, -10, 63, -1, 1};
        raws = '{0, 100, 1000, 16, 1007};
        seed = 32'h0000_003C;
        fails = 0;
        compares = 0;
        nrst = 1'b0;
        full_step = 1'b0;
        raw_load = 10'h000;
        repeat (6) @(negedge clock);
        check("rst_value", 16'(load_measure_value), 16'(LOAD_RST));
        check("rst_offset", 16'(stall_threshold_offset), 16'h0000);
        check("rst_filter", 16'(load_filter_enable), 16'h0000);
        check("rst_stall", 16'(stall_flag_out), 16'h0000);
        nrst = 1'b1;
        @(negedge clock);
        // Saturation corners, then random raw loads back to back.
        foreach (offs[i]) begin
            set_cfg(offs[i], 1'b0);
            unf_step(raws[i][LOAD_W-1:0]);
            r = xorshift();
            unf_step(r[LOAD_W-1:0]);
            drive(1'b0, r[LOAD_W-1:0]);
            check("idle_update", 16'(load_update), 16'h0000);
            check("hold_offset", 16'(stall_threshold_offset), 16'(offs[i][OFFSET_W-1:0]));
        end
        host_tuner_inst.tune(1'b1, 1'b0);
        check("tuned", 16'(stall_threshold_offset), 16'h0000);
        // Filtered mode with a negative offset; a partial group is dropped
        // when filtering is switched off and on again.
        set_cfg(-3, 1'b1);
        drive(1'b1, 10'h3FF);
        drive(1'b1, 10'h3FF);
        check("part_hold", 16'(load_update), 16'h0000);
        drive(1'b0, 10'h000);
        set_cfg(-3, 1'b0);
        drive(1'b0, 10'h000);
        set_cfg(-3, 1'b1);
        // Only every fourth step updates, with the average; group 0 stalls.
        for (int g = 0; g < 3; g++) begin
            sum = 0;
            for (int k = 0; k < 4; k++) begin
                r = (g == 0) ? 32'h0000_0010 : xorshift();
                sum += int'(r[LOAD_W-1:0]);
                drive(1'b1, r[LOAD_W-1:0]);
                check("filt_hold", 16'(load_update), 16'h0000);
            end
            drive(1'b0, r[LOAD_W-1:0]);
            e = exp_load(sum / 4, host_tuner_inst.cur_offset);
            check("filt_update", 16'(load_update), 16'h0001);
            check("filt_value", 16'(load_measure_value), 16'(e));
            check("filt_stall", 16'(stall_flag_out), 16'(e == '0));
        end
        // A reset in mid-run clears both settings, the stall flag and the update, and reloads the value with LOAD_RST.
        nrst = 1'b0;
        repeat (2) @(negedge clock);
        check("mid_offset", 16'(stall_threshold_offset), 16'h0000);
        check("mid_filter", 16'(load_filter_enable), 16'h0000);
        check("mid_value", 16'(load_measure_value), 16'(LOAD_RST));
        check("mid_stall", 16'(stall_flag_out), 16'h0000);
        check("mid_update", 16'(load_update), 16'h0000);
        nrst = 1'b1;
        set_cfg(0, 1'b0);
        unf_step(10'h000);
        finish_test();
    end
endmodule : tb_motor_load_measurement

// ---- hw/load_avg_filter.sv ----
// Purpose: Averages four consecutive full-step load samples.
// Assumes: Samples arrive as single-cycle pulses on the shared clock.
// Notes:   A clear restarts the group of four from nothing.
`timescale 1ns/1ns
module load_avg_filter
    import load_meas_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     nrst,
    load_avg_if.sink      avg
);

    logic [ACC_W-1:0]    acc_r;
    logic [AVG_LOG2-1:0] cnt_r;
    logic [LOAD_W-1:0]   result_r;
    logic                valid_r;
    logic                last_w;
    logic [ACC_W-1:0]    sum_w;

    // ------------------------------------------------------------------
    // Accumulation
    // ------------------------------------------------------------------
    // The fourth sample closes a group; the sum divided by four is the result.
    assign last_w = avg.sample_valid && (cnt_r == AVG_LAST);
    assign sum_w  = acc_r + ACC_W'(avg.sample);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc_r    <= '0;
            cnt_r    <= '0;
            result_r <= LOAD_RST;
            valid_r  <= 1'b0;
        end else if (avg.clear) begin
            acc_r   <= '0;
            cnt_r   <= '0;
            valid_r <= 1'b0;
        end else begin
            valid_r <= last_w;
            if (avg.sample_valid) begin
                cnt_r <= cnt_r + 2'h1;
                acc_r <= last_w ? '0 : sum_w;
            end
            if (last_w) begin
                result_r <= sum_w[ACC_W-1:AVG_LOG2];
            end
        end
    end

    assign avg.result       = result_r;
    assign avg.result_valid = valid_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // A result appears exactly one cycle after the fourth sample.
    avg_group_a: assert property (@(posedge clock) disable iff (!nrst)
        valid_r |-> $past(avg.sample_valid) && $past(cnt_r) == 2'h3
                    && !$past(avg.clear))  // R4
        else $error("Filter result without a fourth sample.");

endmodule : load_avg_filter

// ---- hw/load_avg_if.sv ----
// Purpose: Carries raw samples to the averaging filter and its result back.
// Assumes: Both ends on the same clock.
// Notes:   sample_valid and result_valid are one-cycle pulses.
`timescale 1ns/1ns
interface load_avg_if;
    import load_meas_pkg::*;

    logic [LOAD_W-1:0] sample;
    logic              sample_valid;
    logic              clear;
    logic [LOAD_W-1:0] result;
    logic              result_valid;

    modport src  (output sample, output sample_valid, output clear,
                  input  result, input  result_valid);
    modport sink (input  sample, input  sample_valid, input  clear,
                  output result, output result_valid);
endinterface : load_avg_if

// ---- hw/load_meas_pkg.sv ----
// Purpose: Shared constants for the motor load measurement unit.
// Assumes: One 20 MHz clock, active-low asynchronous reset.
// Notes:   Widths, reset values and scaling live here only.
package load_meas_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned OFFSET_W   = 7;
    localparam int unsigned LOAD_W     = 10;
    localparam int unsigned CALC_W     = 12;
    localparam int unsigned AVG_LOG2   = 2;
    localparam int unsigned ACC_W      = LOAD_W + AVG_LOG2;

    // ------------------------------------------------------------------
    // Reset values and scaling
    // ------------------------------------------------------------------
    localparam logic [OFFSET_W-1:0] OFFSET_RST    = 7'h00;
    localparam logic                FILT_EN_RST   = 1'b0;
    localparam logic [LOAD_W-1:0]   LOAD_RST      = 10'h3FF;
    localparam logic [LOAD_W-1:0]   LOAD_MAX      = 10'h3FF;
    localparam logic [CALC_W-1:0]   CALC_LOAD_MAX = 12'h3FF;
    localparam int unsigned         OFFSET_SHIFT  = 4;
    localparam logic [AVG_LOG2-1:0] AVG_LAST      = 2'h3;

endpackage : load_meas_pkg

// ---- hw/motor_load_measurement.sv ----
// Purpose: Turns the chopper-derived raw load into the reported load value
//          and the stall flag, with an optional four-step average.
// Assumes: raw_load and full_step come from logic on the same clock;
//          the host setting ports are synchronous to that clock.
// Notes:   Higher values mean lighter load; zero means the motor stalled.
//          The offset moves the value in steps of sixteen and the sum is clamped.
//          The value check compares against a separate signed reference of the sum.
`timescale 1ns/1ns

// Operation
// (R1) Accept a 7-bit signed threshold offset, up to +63, to shift range.
// (R2) Negative offsets make stall detection more sensitive, positive less.
// (R3) Host should not program an offset below minus ten.
// (R4) Filter enabled: update once per four full steps with averaged result.
// (R5) Report load as unsigned 10-bit value from 0 to 1023.
// (R6) Larger value for lighter load, near zero at maximum load.
// (R7) Assert stall flag when the load value reaches zero.
// (R8) Host lowers offset if motor stalls first, raises it otherwise.
// (R9) Host starts offset tuning from zero.
// (R10) Filter disabled: refresh load value once every full step.
// (R11) Stall flag output is active high while a stall is signalled.
// (R12) Offset and filter enable reset to zero and hold until written.
module motor_load_measurement
    import load_meas_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                full_step,
    input  wire logic [LOAD_W-1:0]   raw_load,
    input  wire logic                cfg_write,
    input  wire logic [OFFSET_W-1:0] cfg_offset,
    input  wire logic                cfg_filter_en,
    output logic [OFFSET_W-1:0]      stall_threshold_offset,
    output logic                     load_filter_enable,
    output logic [LOAD_W-1:0]        load_measure_value,
    output logic                     stall_flag_out,
    output logic                     load_update
);

    logic [OFFSET_W-1:0] offset_r;
    logic                filt_r;
    logic [LOAD_W-1:0]   value_r;
    logic                stall_r;
    logic                upd_r;
    logic [LOAD_W-1:0]   src_w;
    logic                take_w;
    logic [CALC_W-1:0]   off_ext_w;
    logic [CALC_W-1:0]   off_scaled_w;
    logic [CALC_W-1:0]   sum_w;
    logic [LOAD_W-1:0]   value_nxt;

    load_avg_if avg ();

    // ------------------------------------------------------------------
    // Host settings
    // ------------------------------------------------------------------
    // Settings change only on a host write and are cleared by reset.
    // Both share one strobe, so the filter never meets a half-written offset.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            offset_r <= OFFSET_RST;  // R12
            filt_r   <= FILT_EN_RST;  // R12
        end else if (cfg_write) begin
            offset_r <= cfg_offset;  // R1
            filt_r   <= cfg_filter_en;  // R4
        end
    end

    // ------------------------------------------------------------------
    // Averaging filter
    // ------------------------------------------------------------------
    // Only full steps taken while filtering is on feed the filter; it restarts while filtering is off.
    // Holding it clear while off drops any partial group, so the first
    // filtered result after a mode change is built from four fresh steps.
    assign avg.sample       = raw_load;
    assign avg.sample_valid = full_step && filt_r;
    assign avg.clear        = !filt_r;

    load_avg_filter load_avg_filter_inst (
        .clock (clock),
        .nrst  (nrst),
        .avg   (avg)
    );

    // ------------------------------------------------------------------
    // Source selection and offset correction
    // ------------------------------------------------------------------
    // Filtered mode takes the average once per four steps, else each step.
    assign src_w  = filt_r ? avg.result : raw_load;  // R4
    assign take_w = filt_r ? avg.result_valid : full_step;  // R10

    // The signed offset, scaled up, is added so that a positive offset
    // lifts the value and delays a stall, and a negative one lowers it.
    assign off_ext_w    = {{(CALC_W-OFFSET_W){offset_r[OFFSET_W-1]}}, offset_r};  // R1
    assign off_scaled_w = CALC_W'(off_ext_w << OFFSET_SHIFT);  // R2
    assign sum_w        = {2'b00, src_w} + off_scaled_w;  // R6

    // Saturate to the unsigned 10-bit range.
    // Only a negative sum sets the top bit; positive sums stop at 2031.
    assign value_nxt = sum_w[CALC_W-1]          ? '0 :
                       (sum_w > CALC_LOAD_MAX)  ? LOAD_MAX :
                                                  sum_w[LOAD_W-1:0];  // R5

    // ------------------------------------------------------------------
    // Reported value and stall flag
    // ------------------------------------------------------------------
    // Value and flag update together so the flag always matches the value.
    // The flag is a level, not sticky: a refresh that lifts the value above
    // zero drops it again, so the host must sample it while it stands.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            value_r <= LOAD_RST;
            stall_r <= 1'b0;
            upd_r   <= 1'b0;
        end else begin
            upd_r <= take_w;
            if (take_w) begin
                value_r <= value_nxt;  // R10
                stall_r <= (value_nxt == '0);  // R7
            end
        end
    end

    assign stall_threshold_offset = offset_r;
    assign load_filter_enable     = filt_r;
    assign load_measure_value     = value_r;
    assign stall_flag_out         = stall_r;  // R11
    assign load_update            = upd_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------------
    // Reference for the checks
    // ------------------------------------------------------------------
    // The expected value is built in signed arithmetic instead of the
    // unsigned wrap and top-bit test above, so a slip in either shows up
    // as a mismatch between the two.
    logic signed [CALC_W:0] ref_sum_w;
    logic [LOAD_W-1:0]      ref_val_w;

    assign ref_sum_w = $signed({3'h0, src_w}) + ($signed(offset_r) <<< OFFSET_SHIFT);
    assign ref_val_w = ref_sum_w[CALC_W]                        ? '0 :
                       (ref_sum_w > $signed({3'h0, LOAD_MAX})) ? LOAD_MAX :
                                                                  ref_sum_w[LOAD_W-1:0];

    // Settings hold between host writes.
    cfg_hold_a: assert property (!cfg_write |=> $stable(offset_r) && $stable(filt_r))  // R12
        else $error("Settings changed without a write.");

    // A write loads the offset as given.
    cfg_load_a: assert property (cfg_write |=> offset_r == $past(cfg_offset))  // R1
        else $error("Offset not taken on write.");

    // Unfiltered: each full step refreshes the value next cycle.
    unfilt_step_a: assert property (full_step && !filt_r && !cfg_write
        |=> upd_r && value_r == $past(value_nxt))  // R10
        else $error("Unfiltered step did not refresh the value.");

    // Filtered: a bare step does not move the value.
    filt_hold_a: assert property (filt_r && !avg.result_valid
        |=> $stable(value_r))  // R4
        else $error("Filtered value moved without a result.");

    // Non-negative offset never lowers the value below the raw sample.
    pos_offset_a: assert property (full_step && !filt_r && !offset_r[OFFSET_W-1]
        |=> value_r >= $past(raw_load))  // R2
        else $error("Positive offset lowered the value.");

    // Negative offset never raises the value above the raw sample.
    neg_offset_a: assert property (full_step && !filt_r && offset_r[OFFSET_W-1]
        |=> value_r <= $past(raw_load))  // R2
        else $error("Negative offset raised the value.");

    // Stall flag high exactly when the value is zero.
    stall_match_a: assert property (stall_r == (value_r == '0))  // R7
        else $error("Stall flag does not match zero value.");

    // With zero offset the raw sample passes unchanged.
    zero_pass_a: assert property (full_step && !filt_r && offset_r == '0
        |=> value_r == $past(raw_load))  // R6
        else $error("Zero offset altered the value.");

    // Every refresh reports the offset-shifted source, clamped to 0..1023.
    value_calc_a: assert property (take_w |=> value_r == $past(ref_val_w))  // R5
        else $error("Reported value differs from the clamped sum.");

    // Between refreshes the value and the stall flag stand still.
    value_hold_a: assert property (!take_w |=> $stable(value_r) && $stable(stall_r))  // R10
        else $error("Value or flag moved without a refresh.");

    // An unfiltered refresh always traces back to a full step.
    upd_step_a: assert property (upd_r && !$past(filt_r) |-> $past(full_step))  // R10
        else $error("Unfiltered refresh without a full step.");

    // A filter result follows a filtered full step by one cycle.
    filt_result_a: assert property (avg.result_valid  // R4
        |-> $past(full_step) && $past(filt_r))
        else $error("Filter result without a filtered step.");

    // Filtered updates are single pulses, never two in a row.
    filt_once_a: assert property (upd_r && filt_r && !cfg_write |=> !upd_r)  // R4
        else $error("Filtered update lasted more than one cycle.");

    // A write loads the filter enable as given.
    cfg_filt_a: assert property (cfg_write |=> filt_r == $past(cfg_filter_en))  // R4
        else $error("Filter enable not taken on write.");

    // A heavier raw load never reports a lighter value at the same offset.
    mono_load_a: assert property (full_step && !filt_r && !cfg_write  // R6
        ##1 full_step && !filt_r && !cfg_write && raw_load <= $past(raw_load)
        |=> value_r <= $past(value_r))
        else $error("Heavier load reported a larger value.");

    // Main scenarios: each mode's update, a stall, top saturation, mode exit.
    unfilt_upd_c: cover property (full_step && !filt_r ##1 upd_r);
    filt_upd_c:   cover property (filt_r && avg.result_valid ##1 upd_r);
    stall_c:      cover property ($rose(stall_r));
    sat_top_c:    cover property (upd_r && value_r == LOAD_MAX);
    filt_off_c:   cover property (filt_r ##1 !filt_r);

endmodule : motor_load_measurement
